//--- design/dsgs_pkg.sv
`default_nettype none
package dsgs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DECEL = 8'h04;
   localparam logic [7:0] OFS_TIME = 8'h08;
   localparam logic [7:0] OFS_EARLY = 8'h14;
   localparam logic [7:0] OFS_END = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_STEP = 8'h04;
   // Control register fields
   localparam int CTRL_W = 6;
   localparam int CTRL_AUTO_RESET = 0;
   localparam int CTRL_TQ_OFF_LOW = 1;
   localparam int CTRL_RAMP_BASE = 2;
   localparam int CTRL_EARLY = 5;
   // Ramp on for safe stop one, everything else off, high side selected
   localparam logic [5:0] CTRL_RESET = 6'h04;
   localparam logic [31:0] DECEL_RESET = 32'h3FFF0001;
   localparam logic [31:0] TIME_RESET = 32'h00000000;
   // Status register fields
   localparam int STAT_ACTIVE = 3;
   localparam int STAT_REACHED = 6;
   localparam int STAT_ERROR = 9;
   // Function index of the supervisors
   localparam int FN_STOP_ONE = 0;
   localparam int FN_STOP_TWO = 1;
   localparam int FN_LIM_SPEED = 2;
   localparam int FN_N = 3;
   // Timing: a one microsecond tick for time and ramp supervision
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Ramp envelope is kept in speed units times ticks per second
   localparam logic [63:0] ENV_SCALE = 64'h00000000000F4240;
   typedef enum logic [2:0] {
      DSGS_INIT = 3'b001,
      DSGS_OPER = 3'b010,
      DSGS_FAIL = 3'b100
   } dsgs_state_t;
   typedef enum logic [2:0] {
      DSGS_MON_IDLE = 3'b001,
      DSGS_MON_RAMP = 3'b010,
      DSGS_MON_SAFE = 3'b100
   } dsgs_mon_state_t;
endpackage
`default_nettype wire

//--- design/dsgs_ramp_mon.sv
`timescale 1ns/1ns
`default_nettype none
module dsgs_ramp_mon (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic tick_us,
   // Configuration
   input wire logic ramp_en,
   input wire logic early_en,
   input wire logic [31:0] decel,
   input wire logic [31:0] time_lim,
   input wire logic [31:0] early_time,
   input wire logic [31:0] end_speed,
   // Request and measured speed
   input wire logic request,
   input wire logic [31:0] speed,
   // Results
   output logic active,
   output logic reached,
   output logic error
);
   import dsgs_pkg::*;

   typedef struct packed {
      dsgs_mon_state_t st;
      logic [63:0] env;
      logic [31:0] timer;
      logic [31:0] below_cnt;
      logic error;
   } dsgs_mon_t;

   dsgs_mon_t r, next_r;
   logic [63:0] speed_scaled;
   logic below;

   assign speed_scaled = {32'h00000000, speed} * ENV_SCALE;
   assign below = speed <= end_speed;

   // Ramp and time supervision of one stop function
   always_comb begin
      next_r = r;
      case (r.st)
         DSGS_MON_IDLE: begin
            if (request) begin
               next_r.st = DSGS_MON_RAMP;
               next_r.env = speed_scaled;
               next_r.timer = 32'h00000000;
               next_r.below_cnt = 32'h00000000;
               next_r.error = 1'b0;
            end
         end
         DSGS_MON_RAMP: begin
            if (!request) begin
               next_r.st = DSGS_MON_IDLE;
            end else begin
               if (tick_us) begin
                  next_r.timer = r.timer + 32'h00000001;
                  // Envelope falls by the slope once per microsecond, floored at zero
                  next_r.env = (r.env > {32'h00000000, decel}) ? r.env - {32'h00000000, decel}
                                                              : 64'h0000000000000000;
                  next_r.below_cnt = below ? r.below_cnt + 32'h00000001 : 32'h00000000;
               end
               if (ramp_en && speed_scaled > r.env) begin
                  next_r.error = 1'b1;
                  next_r.st = DSGS_MON_SAFE;
               end else if (early_en && below && r.below_cnt >= early_time) begin
                  next_r.st = DSGS_MON_SAFE;
               end else if (r.timer >= time_lim) begin
                  // Time is always watched; missing the end speed by then is a fault
                  next_r.st = DSGS_MON_SAFE;
                  next_r.error = !below;
               end
            end
         end
         DSGS_MON_SAFE: begin
            if (!request) begin
               next_r.st = DSGS_MON_IDLE;
            end
         end
         default: begin
            next_r.st = DSGS_MON_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '{st: DSGS_MON_IDLE, env: 64'h0000000000000000, timer: 32'h00000000,
                below_cnt: 32'h00000000, error: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign active = r.st == DSGS_MON_RAMP;
   assign reached = (r.st == DSGS_MON_SAFE) && !r.error;
   assign error = r.error;
endmodule
`default_nettype wire

//--- design/dsgs_top.sv
// Behaviour
// - Auto start reset enters Operational by itself
// - Otherwise wait in Init for reset rising edge
// - One-channel torque off drives selected side, high default
// - Safe stop one: ramp plus time, ramp default
// - Safe stop two: optional ramp plus time
// - Limited speed: optional ramp plus time
// - Early limit: below end speed long enough
// - Ramp slope configurable, default 1073676289
// - Operational releases pulses and holding brake until safe stop one is reached
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module dsgs_top (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Safety controller requests
   input wire logic reset_in,
   input wire logic net_fail,
   input wire logic one_channel_torque_off,
   input wire logic safe_stop_one,
   input wire logic safe_stop_two,
   input wire logic safely_limited_speed,
   input wire logic [31:0] speed,
   // Power stage
   output logic high_side_enable,
   output logic low_side_enable,
   output logic pulse_enable,
   output logic brake_release,
   output logic fail_safe
);
   import dsgs_pkg::*;

   typedef struct packed {
      dsgs_state_t st;
      logic [CTRL_W-1:0] ctrl;
      logic [31:0] decel;
      logic [FN_N-1:0][31:0] time_lim;
      logic [31:0] early_time;
      logic [FN_N-1:0][31:0] end_speed;
      logic [31:0] rdata;
      logic reset_d;
      logic [7:0] tick_cnt;
      logic tick;
      logic high_en;
      logic low_en;
      logic pulse_en;
      logic brake_rel;
      logic fail;
   } dsgs_top_t;

   dsgs_top_t r, next_r;
   logic [FN_N-1:0] req, mon_active, mon_reached, mon_error;
   logic [31:0] status;

   assign req = {safely_limited_speed, safe_stop_two, safe_stop_one};

   // One supervisor per stop function; each is idle unless Operational
   genvar g;
   generate
      for (g = 0; g < FN_N; g++) begin : g_mon
         dsgs_ramp_mon u_mon (
            .clk(clk),
            .srst(srst),
            .tick_us(r.tick),
            .ramp_en(r.ctrl[CTRL_RAMP_BASE + g]),
            .early_en(r.ctrl[CTRL_EARLY]),
            .decel(r.decel),
            .time_lim(r.time_lim[g]),
            .early_time(r.early_time),
            .end_speed(r.end_speed[g]),
            .request(req[g] && r.st == DSGS_OPER),
            .speed(speed),
            .active(mon_active[g]),
            .reached(mon_reached[g]),
            .error(mon_error[g])
         );
      end
   endgenerate

   assign status = {20'h00000, mon_error, mon_reached, mon_active, r.st};

   // Register access, tick divider, restart state and power stage drive
   always_comb begin
      next_r = r;
      next_r.reset_d = reset_in;
      // Tick pulse every microsecond
      if (r.tick_cnt == 8'(TICK_CYC - 1)) begin
         next_r.tick_cnt = 8'h00;
         next_r.tick = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 8'h01;
         next_r.tick = 1'b0;
      end
      // Writes
      if (wr) begin
         if (addr == OFS_CTRL) begin
            next_r.ctrl = wdata[CTRL_W-1:0];
         end
         if (addr == OFS_DECEL) begin
            next_r.decel = wdata;
         end
         if (addr == OFS_EARLY) begin
            next_r.early_time = wdata;
         end
         for (int i = 0; i < FN_N; i++) begin
            if (addr == 8'(OFS_TIME + OFS_STEP * 8'(i))) begin
               next_r.time_lim[i] = wdata;
            end
            if (addr == 8'(OFS_END + OFS_STEP * 8'(i))) begin
               next_r.end_speed[i] = wdata;
            end
         end
      end
      // Reads answer one cycle later; unmapped addresses read zero
      next_r.rdata = 32'h00000000;
      if (rd) begin
         if (addr == OFS_CTRL) begin
            next_r.rdata = {26'h0000000, r.ctrl};
         end
         if (addr == OFS_DECEL) begin
            next_r.rdata = r.decel;
         end
         if (addr == OFS_EARLY) begin
            next_r.rdata = r.early_time;
         end
         if (addr == OFS_STATUS) begin
            next_r.rdata = status;
         end
         for (int i = 0; i < FN_N; i++) begin
            if (addr == 8'(OFS_TIME + OFS_STEP * 8'(i))) begin
               next_r.rdata = r.time_lim[i];
            end
            if (addr == 8'(OFS_END + OFS_STEP * 8'(i))) begin
               next_r.rdata = r.end_speed[i];
            end
         end
      end
      // Restart inhibit; a fault is only left through srst
      case (r.st)
         DSGS_INIT: begin
            if (r.ctrl[CTRL_AUTO_RESET]) begin
               next_r.st = DSGS_OPER;
            end else if (reset_in && !r.reset_d) begin
               next_r.st = DSGS_OPER;
            end
         end
         DSGS_OPER: begin
            if (|mon_error) begin
               next_r.st = DSGS_FAIL;
            end else if (net_fail) begin
               // Network loss re-arms the restart inhibit
               next_r.st = DSGS_INIT;
            end
         end
         DSGS_FAIL: begin
            next_r.st = DSGS_FAIL;
         end
         default: begin
            next_r.st = DSGS_FAIL;
         end
      endcase
      // Outputs follow the state computed for the next cycle
      next_r.fail = next_r.st == DSGS_FAIL;
      next_r.pulse_en = (next_r.st == DSGS_OPER) && !mon_reached[FN_STOP_ONE];
      next_r.brake_rel = next_r.pulse_en;
      next_r.high_en = next_r.pulse_en &&
                       !(one_channel_torque_off && !r.ctrl[CTRL_TQ_OFF_LOW]);
      next_r.low_en = next_r.pulse_en &&
                      !(one_channel_torque_off && r.ctrl[CTRL_TQ_OFF_LOW]);
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '{st: DSGS_INIT, ctrl: CTRL_RESET, decel: DECEL_RESET,
                time_lim: {FN_N{TIME_RESET}}, early_time: TIME_RESET,
                end_speed: {FN_N{TIME_RESET}}, rdata: 32'h00000000, reset_d: 1'b1,
                tick_cnt: 8'h00, tick: 1'b0, high_en: 1'b0, low_en: 1'b0,
                pulse_en: 1'b0, brake_rel: 1'b0, fail: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
   assign high_side_enable = r.high_en;
   assign low_side_enable = r.low_en;
   assign pulse_enable = r.pulse_en;
   assign brake_release = r.brake_rel;
   assign fail_safe = r.fail;
endmodule
`default_nettype wire

//--- bench/dsgs_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsgs_ctrl_model (
   // Clock
   input wire logic clk,
   // Requests: {limited speed, stop two, stop one, torque off}
   output logic reset_in,
   output logic net_fail,
   output logic [3:0] req,
   output logic [31:0] speed
);
   initial begin
      {reset_in, net_fail, req, speed} = 38'h0;
   end
   // Pulse starts low, so a level held high is never taken for an edge
   task restart(input int gap);
      @(posedge clk) reset_in <= 1'h0;
      repeat (gap) @(posedge clk);
      reset_in <= 1'h1;
      @(posedge clk) reset_in <= 1'h0;
   endtask
   // Requests are levels, changed just after an edge
   task drive(input logic [3:0] r, input logic [31:0] s, input logic nf);
      @(posedge clk);
      req <= r;
      speed <= s;
      net_fail <= nf;
   endtask
endmodule
`default_nettype wire

//--- bench/dsgs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dsgs_chk (
   // Clock, reset and bus
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   // Controller and power stage
   input wire logic reset_in,
   input wire logic net_fail,
   input wire logic one_channel_torque_off,
   input wire logic high_side_enable,
   input wire logic low_side_enable,
   input wire logic pulse_enable,
   input wire logic brake_release,
   input wire logic fail_safe
);
   logic low_sel;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // Shadow of the side bit; a read-back would cost bus cycles
   always_ff @(posedge clk) begin
      if (srst) begin
         low_sel <= 1'h0;
      end else if (wr && addr == 8'h00) begin
         low_sel <= wdata[1];
      end
   end
   AST_AUTO_START: assert property (
      wr && addr == 8'h00 && wdata[0] |-> ##[1:4] pulse_enable) else $error("no auto start");
   AST_EDGE_START: assert property (
      $rose(reset_in) |-> ##[1:4] pulse_enable) else $error("no start on edge");
   AST_STAY_INIT: assert property (
      $fell(srst) |-> !pulse_enable [*5]) else $error("left init alone");
   // Side bit must have settled, so the write edge itself is skipped
   AST_TQ_OFF_SIDE: assert property (
      one_channel_torque_off && $past(one_channel_torque_off, 2) && $stable(low_sel)
      |-> !(low_sel ? low_side_enable : high_side_enable)) else $error("wrong side");
   AST_BRAKE_PAIR: assert property (
      $rose(pulse_enable) |-> brake_release) else $error("brake held");
   AST_NET_DROP: assert property (
      $rose(net_fail) |-> ##[1:3] !pulse_enable) else $error("no drop on net fail");
   AST_FAIL_STICKY: assert property (
      fail_safe |=> fail_safe) else $error("fail-safe left");
   AST_FAIL_OFF: assert property (
      fail_safe |-> !(pulse_enable || high_side_enable || low_side_enable)) else $error("on");
   C_START: cover property ($rose(pulse_enable));
   C_STOP: cover property ($fell(pulse_enable) && !fail_safe);
   C_FAIL: cover property ($rose(fail_safe));
endmodule
bind dsgs_top dsgs_chk chk_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
   .reset_in(reset_in), .net_fail(net_fail), .one_channel_torque_off(one_channel_torque_off),
   .high_side_enable(high_side_enable), .low_side_enable(low_side_enable),
   .pulse_enable(pulse_enable), .brake_release(brake_release), .fail_safe(fail_safe));
`default_nettype wire

//--- bench/test_drive_safety_general_settings.sv
`timescale 1ns/1ns
`default_nettype none
module test_drive_safety_general_settings;
   import dsgs_pkg::*;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata, speed;
   logic [3:0] req;
   logic reset_in, net_fail, hse, lse, pe, br, fs;
   int num_errors = 0;
   int checks_done = 0;
   always #10 clk = ~clk;
   dsgs_ctrl_model ctrl_u (.clk(clk), .reset_in(reset_in), .net_fail(net_fail), .req(req),
      .speed(speed));
   dsgs_top dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .reset_in(reset_in), .net_fail(net_fail), .one_channel_torque_off(req[0]),
      .safe_stop_one(req[1]), .safe_stop_two(req[2]), .safely_limited_speed(req[3]),
      .speed(speed), .high_side_enable(hse), .low_side_enable(lse), .pulse_enable(pe),
      .brake_release(br), .fail_safe(fs));
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk) wr <= 1'h0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk) rd <= 1'h0;
      #1 chk(what, rdata, exp);
   endtask
   // Bounded wait on pulse enable (sel 0) or fail-safe (sel 1), sampled mid-cycle
   task wait_out(input bit sel, input logic v, input int n);
      int i;
      for (i = 0; i < n && (sel ? fs : pe) !== v; i++) @(negedge clk);
      chk(sel ? "fail" : "pulse", 32'(sel ? fs : pe), 32'(v));
      if (i == n) summarize();
   endtask
   task do_reset;
      @(posedge clk) srst <= 1'h1;
      repeat (12) @(posedge clk);
      srst <= 1'h0;
   endtask
   task start(input int gap);
      ctrl_u.restart(gap);
      wait_out(0, 1'h1, 8);
   endtask
   task t_init;
      rd_chk("ctrl", OFS_CTRL, 32'h4);
      rd_chk("decel", OFS_DECEL, 32'h3FFF0001);
      rd_chk("unmapped", 8'hFC, 32'h0);
      repeat (10) @(negedge clk);
      chk("init", 32'(pe), 32'h0);
      start(6);
      chk("brake", 32'(br), 32'h1);
      rd_chk("status", OFS_STATUS, 32'h2);
      $display("init done");
   endtask
   task t_torque_off;
      ctrl_u.drive(4'h1, 32'h0, 1'h0);
      repeat (3) @(negedge clk);
      chk("high", 32'({hse, lse}), 32'h1);
      wr_reg(OFS_CTRL, 32'h6);
      repeat (3) @(negedge clk);
      chk("low", 32'({hse, lse}), 32'h2);
      ctrl_u.drive(4'h0, 32'h0, 1'h0);
      $display("torque off done");
   endtask
   // Time-only stop, then early limit far ahead of a long time limit
   task t_stop;
      wr_reg(OFS_CTRL, 32'h0);
      wr_reg(OFS_TIME, 32'h4);
      wr_reg(OFS_END, 32'h64);
      ctrl_u.drive(4'h2, 32'h32, 1'h0);
      wait_out(0, 1'h0, 320);
      chk("fault", 32'(fs), 32'h0);
      ctrl_u.drive(4'h0, 32'h0, 1'h0);
      wait_out(0, 1'h1, 10);
      wr_reg(OFS_CTRL, 32'h20);
      wr_reg(OFS_TIME, 32'h3E8);
      wr_reg(OFS_EARLY, 32'h2);
      ctrl_u.drive(4'h2, 32'h0, 1'h0);
      wait_out(0, 1'h0, 200);
      ctrl_u.drive(4'h0, 32'h0, 1'h0);
      $display("stop done");
   endtask
   // Each function: no fault with ramp off, ramp fault with ramp on
   task t_ramp;
      int f;
      for (f = 0; f < 3; f++) begin
         wr_reg(OFS_CTRL, 32'h0);
         wr_reg(8'(OFS_TIME + 4 * f), 32'h3E8);
         ctrl_u.drive(4'(2 << f), 32'hA, 1'h0);
         repeat (300) @(negedge clk);
         chk("time only", 32'(fs), 32'h0);
         ctrl_u.drive(4'h0, 32'hA, 1'h0);
         wr_reg(OFS_CTRL, 32'(4 << f));
         ctrl_u.drive(4'(2 << f), 32'hA, 1'h0);
         wait_out(1, 1'h1, 300);
         chk("off", 32'({pe, hse, lse}), 32'h0);
         // Fail state plus the error bit of the function that tripped
         rd_chk("fail status", OFS_STATUS, 32'h4 | (32'h200 << f));
         ctrl_u.drive(4'h0, 32'h0, 1'h0);
         do_reset();
         // Edge comes late enough that Init is seen to hold first
         start(6);
      end
      $display("ramp done");
   endtask
   task t_auto;
      do_reset();
      repeat (6) @(posedge clk);
      wr_reg(OFS_CTRL, 32'h5);
      wait_out(0, 1'h1, 6);
      ctrl_u.drive(4'h0, 32'h0, 1'h1);
      ctrl_u.drive(4'h0, 32'h0, 1'h0);
      wait_out(0, 1'h0, 4);
      wait_out(0, 1'h1, 6);
      $display("auto done");
   endtask
   initial begin
      do_reset();
      t_init();
      t_torque_off();
      t_stop();
      t_ramp();
      t_auto();
      summarize();
   end
endmodule
`default_nettype wire
